// File: board_cfg_pkg.sv
// Package: constants, layout and states of the sensor board configuration loader
//Contract
//RULE1 - Shipped serial: 115200 baud, no parity, 1 stop
//RULE2 - Check user flash integrity at every boot
//RULE3 - User flash keeps power, threshold, integration, serial
//RULE4 - Good user check reports status OK
//RULE5 - Bad user check: factory serial, address 255
//RULE6 - Bad user check reports status BAD USER
//RULE7 - Bad calibration check reports distinct status
//RULE8 - Node address stored in flash, loaded at boot
//RULE9 - Host may write baud, parity, stop, address
//RULE10 - New settings saved now, active after reboot; power, threshold and integration apply at once
//RULE11 - Reboot command restarts and reloads flash
//RULE12 - Broadcast address query answered with own address
//RULE13 - Host sends broadcast query with one board only
//RULE14 - Host gives every board a unique address
//RULE15 - Laser power 0..1023, host readable
//RULE16 - Detection threshold 0..1023, host readable; config read frame returns its top seven bits only
//RULE17 - Config read returns fault, voltage, serial, version, status
//RULE18 - Integration time counts 16 MHz, 3..4165
//RULE19 - Ignore other addresses; answer own or broadcast query
`default_nettype none
package board_cfg_pkg;
	// User flash word map
	localparam logic [2:0] UW_COMM = 3'h0;
	localparam logic [2:0] UW_POWER = 3'h1;
	localparam logic [2:0] UW_THRESH = 3'h2;
	localparam logic [2:0] UW_INTEG = 3'h3;
	localparam logic [2:0] UW_CHECK = 3'h4;
	localparam logic [2:0] UW_LAST = 3'h4;
	localparam int USER_WORDS = 5;
	// Comm word fields: [7:0] addr, [10:8] baud code, [12:11] parity, [13] stop
	localparam int F_ADDR_LSB = 0;
	localparam int F_BAUD_LSB = 8;
	localparam int F_PAR_LSB = 11;
	localparam int F_STOP_BIT = 13;
	localparam logic [2:0] BAUD_115200 = 3'h7;
	localparam logic [1:0] PARITY_NONE = 2'h0;
	localparam logic STOP_ONE = 1'b0;
	localparam logic [7:0] FALLBACK_ADDR = 8'hff;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [15:0] CHECK_SEED = 16'ha5a5;
	// Ranges
	localparam logic [9:0] SETTING_MAX = 10'h3ff;
	localparam logic [12:0] INTEG_MIN = 13'h0003;
	localparam logic [12:0] INTEG_MAX = 13'h1045;
	localparam logic [12:0] INTEG_DEFAULT = 13'h0003;
	// Flash status codes
	localparam logic [1:0] FS_OK = 2'h0;
	localparam logic [1:0] FS_BAD_USER = 2'h1;
	localparam logic [1:0] FS_BAD_PROT = 2'h2;
	// Frame function codes
	localparam logic [3:0] FN_READ_CFG = 4'h1;
	localparam logic [3:0] FN_WRITE_COMM = 4'h2;
	localparam logic [3:0] FN_WRITE_SET = 4'h3;
	localparam logic [3:0] FN_REBOOT = 4'h4;
	localparam logic [3:0] FN_QUERY_ADDR = 4'h5;
	// Software registers
	localparam logic [3:0] R_STATUS = 4'h0;
	localparam logic [3:0] R_MASK = 4'h1;
	localparam logic [3:0] R_ACTIVE = 4'h2;
	localparam logic [3:0] R_STORED = 4'h3;
	localparam logic [3:0] R_POWER = 4'h4;
	localparam logic [3:0] R_THRESH = 4'h5;
	localparam logic [3:0] R_INTEG = 4'h6;
	localparam logic [3:0] R_FLASH = 4'h7;
	localparam logic [3:0] R_CMD = 4'h8;
	localparam int CMD_REBOOT_BIT = 0;
	// Event bits
	localparam int EV_BOOT = 0;
	localparam int EV_BAD_USER = 1;
	localparam int EV_BAD_PROT = 2;
	localparam int EV_SAVED = 3;
	localparam int EV_IGNORED = 4;
	localparam int EV_BITS = 5;
	typedef enum {ST_RESET, ST_USER_READ, ST_PROT_CHECK, ST_APPLY, ST_RUN,
		ST_SAVE} state_type;
	function automatic logic [15:0] check_step(input logic [15:0] acc,
			input logic [15:0] data);
		check_step = {acc[14:0], acc[15]} ^ data;
	endfunction
endpackage
`default_nettype wire

// File: user_flash_mem.sv
// Small user flash image with registered read port
`default_nettype none
module user_flash_mem
	import board_cfg_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [15:0] wr_data,
	// Read port
	input wire logic [2:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem [USER_WORDS];
	always_ff @(posedge clk_sys) begin
		if (wr_en)
			mem[wr_addr] <= wr_data; // RULE3
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// File: frame_decoder.sv
// Address filter and function decode for incoming frames
`default_nettype none
module frame_decoder
	import board_cfg_pkg::*;
(
	// Frame in
	input wire logic frame_valid,
	input wire logic [7:0] frame_addr,
	input wire logic [3:0] frame_func,
	// Own address
	input wire logic [7:0] node_addr,
	// Decoded
	output logic accept,
	output logic ignored
);
	logic own;
	logic bq;
	always_comb begin
		own = frame_addr == node_addr;
		bq = frame_addr == BCAST_ADDR && frame_func == FN_QUERY_ADDR;
		accept = frame_valid && (own || bq); // RULE19
		ignored = frame_valid && !(own || bq);
	end
endmodule
`default_nettype wire

// File: board_cfg_loader.sv
// Boot configuration loader and communication settings of one sensor board
//
// Chosen here: the register offsets and the address-and-strobe port.
`default_nettype none
module board_cfg_loader
	import board_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Calibration area check result, valid while prot_ready
	input wire logic prot_ready,
	input wire logic prot_good,
	// Board identity and sensed values
	input wire logic laser_fault,
	input wire logic [11:0] input_voltage,
	input wire logic [15:0] serial_number,
	input wire logic [15:0] firmware_version,
	// Frames from the link, one-cycle strobe
	input wire logic frame_valid,
	input wire logic [7:0] frame_addr,
	input wire logic [3:0] frame_func,
	input wire logic [15:0] frame_data0,
	input wire logic [15:0] frame_data1,
	input wire logic [15:0] frame_data2,
	// Reply to the link
	output logic reply_valid,
	output logic [7:0] reply_addr,
	output logic [3:0] reply_func,
	output logic [63:0] reply_data,
	// Active settings
	output logic [7:0] node_addr,
	output logic [2:0] baud_code,
	output logic [1:0] parity_mode,
	output logic stop_bits,
	output logic [9:0] laser_power,
	output logic [9:0] threshold,
	output logic [12:0] integ_time,
	output logic [1:0] flash_status,
	output logic config_ready,
	// Software register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq
);
	typedef struct packed {
		state_type st;
		logic [2:0] idx;
		logic [15:0] acc;
		logic [15:0] comm_img;
		logic [9:0] power;
		logic [9:0] thresh;
		logic [12:0] integ;
		logic [15:0] stored_comm;
		logic [7:0] addr;
		logic [2:0] baud;
		logic [1:0] par;
		logic stop;
		logic [1:0] fstat;
		logic ready;
		logic [2:0] save_idx;
		logic r_valid;
		logic [7:0] r_addr;
		logic [3:0] r_func;
		logic [63:0] r_data;
		logic [EV_BITS-1:0] status;
		logic [EV_BITS-1:0] mask;
		logic [15:0] rdata;
	} state_reg_type;

	state_reg_type cur;
	state_reg_type next_cur;
	logic [15:0] mem_rdata;
	logic mem_wr;
	logic [2:0] mem_waddr;
	logic [15:0] mem_wdata;
	logic [2:0] mem_raddr;
	logic accept;
	logic ignored;

	function automatic logic [15:0] user_word(input state_reg_type s, input logic [2:0] i);
		case (i)
			UW_COMM: user_word = s.stored_comm;
			UW_POWER: user_word = {6'h00, s.power};
			UW_THRESH: user_word = {6'h00, s.thresh};
			UW_INTEG: user_word = {3'h0, s.integ};
			default: user_word = 16'h0000;
		endcase
	endfunction

	function automatic logic [12:0] clamp_integ(input logic [12:0] v);
		if (v < INTEG_MIN)
			clamp_integ = INTEG_MIN;
		else if (v > INTEG_MAX)
			clamp_integ = INTEG_MAX;
		else
			clamp_integ = v;
	endfunction

	user_flash_mem u_mem (
		.clk_sys(clk_sys),
		.wr_en(mem_wr),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata)
	);

	frame_decoder u_dec (
		.frame_valid(frame_valid && cur.st == ST_RUN),
		.frame_addr(frame_addr),
		.frame_func(frame_func),
		.node_addr(cur.addr),
		.accept(accept),
		.ignored(ignored)
	);

	always_comb begin
		logic [EV_BITS-1:0] ev;
		logic [15:0] chk;
		logic reboot;
		ev = '0;
		chk = 16'h0000;
		reboot = 1'b0;
		next_cur = cur;
		next_cur.r_valid = 1'b0;
		mem_wr = 1'b0;
		mem_waddr = cur.save_idx;
		mem_wdata = user_word(cur, cur.save_idx);
		mem_raddr = cur.idx;
		case (cur.st)
			ST_RESET: begin
				next_cur.idx = UW_COMM;
				next_cur.acc = CHECK_SEED;
				next_cur.ready = 1'b0;
				next_cur.st = ST_USER_READ;
			end
			ST_USER_READ: begin
				// Read data lags address by one cycle
				if (cur.idx != UW_COMM || cur.acc != CHECK_SEED || cur.ready) begin
					next_cur.acc = check_step(cur.acc, mem_rdata); // RULE2
				end
				next_cur.ready = 1'b1;
				if (cur.ready) begin
					case (cur.idx - 3'h1)
						UW_COMM: next_cur.comm_img = mem_rdata; // RULE8
						UW_POWER: next_cur.power = mem_rdata[9:0];
						UW_THRESH: next_cur.thresh = mem_rdata[9:0];
						UW_INTEG: next_cur.integ = clamp_integ(mem_rdata[12:0]);
						default: next_cur.power = cur.power;
					endcase
				end
				if (cur.idx == UW_LAST + 3'h1) begin
					next_cur.st = ST_PROT_CHECK;
				end else begin
					next_cur.idx = cur.idx + 3'h1;
				end
			end
			ST_PROT_CHECK: begin
				if (prot_ready) begin
					next_cur.st = ST_APPLY;
				end
			end
			ST_APPLY: begin
				// Check word must cancel the running sum
				chk = cur.acc;
				if (!prot_good) begin
					next_cur.fstat = FS_BAD_PROT; // RULE7
					ev[EV_BAD_PROT] = 1'b1;
				end else if (chk != 16'h0000) begin
					next_cur.fstat = FS_BAD_USER; // RULE6
					ev[EV_BAD_USER] = 1'b1;
				end else begin
					next_cur.fstat = FS_OK; // RULE4
				end
				if (chk != 16'h0000) begin
					next_cur.addr = FALLBACK_ADDR; // RULE5
					next_cur.baud = BAUD_115200;
					next_cur.par = PARITY_NONE;
					next_cur.stop = STOP_ONE;
					next_cur.power = '0;
					next_cur.thresh = '0;
					next_cur.integ = INTEG_DEFAULT;
					next_cur.stored_comm = {2'h0, STOP_ONE, PARITY_NONE, BAUD_115200,
						FALLBACK_ADDR};
				end else begin
					next_cur.addr = cur.comm_img[F_ADDR_LSB +: 8]; // RULE8
					next_cur.baud = cur.comm_img[F_BAUD_LSB +: 3];
					next_cur.par = cur.comm_img[F_PAR_LSB +: 2];
					next_cur.stop = cur.comm_img[F_STOP_BIT];
					next_cur.stored_comm = cur.comm_img;
				end
				ev[EV_BOOT] = 1'b1;
				next_cur.ready = 1'b1;
				next_cur.st = ST_RUN;
			end
			ST_SAVE: begin
				// Write the whole image so the check word stays consistent
				mem_wr = 1'b1; // RULE10
				if (cur.save_idx == UW_CHECK) begin
					// Rotated sum, so the boot step over this word lands on zero
					mem_wdata = check_step(cur.acc, 16'h0000);
					next_cur.st = ST_RUN;
					ev[EV_SAVED] = 1'b1;
				end else begin
					next_cur.acc = check_step(cur.acc, user_word(cur, cur.save_idx));
					next_cur.save_idx = cur.save_idx + 3'h1;
				end
			end
			ST_RUN: begin
				if (accept) begin
					case (frame_func)
						FN_READ_CFG: begin
							next_cur.r_valid = 1'b1; // RULE17
							// Fits 64 bits: threshold keeps its top seven bits only
							next_cur.r_data = {laser_fault, cur.fstat, input_voltage,
								serial_number, firmware_version, cur.power, cur.thresh[9:3]};
						end
						FN_WRITE_COMM: begin
							// Only the stored image changes; active copy waits for reboot
							next_cur.stored_comm = frame_data0; // RULE9
							next_cur.st = ST_SAVE;
						end
						FN_WRITE_SET: begin
							next_cur.power = frame_data0[9:0] & SETTING_MAX; // RULE15
							next_cur.thresh = frame_data1[9:0] & SETTING_MAX; // RULE16
							next_cur.integ = clamp_integ(frame_data2[12:0]); // RULE18
							next_cur.st = ST_SAVE;
						end
						FN_REBOOT: reboot = 1'b1; // RULE11
						FN_QUERY_ADDR: begin
							next_cur.r_valid = 1'b1; // RULE12
							next_cur.r_data = {56'h0, cur.addr};
						end
						default: next_cur.r_valid = 1'b0;
					endcase
					next_cur.r_addr = cur.addr;
					next_cur.r_func = frame_func;
				end
				if (next_cur.st == ST_SAVE) begin
					next_cur.save_idx = UW_COMM;
					next_cur.acc = CHECK_SEED;
				end
			end
			default: next_cur.st = ST_RESET;
		endcase
		if (ignored)
			ev[EV_IGNORED] = 1'b1;
		// Software register port; event set beats clear
		next_cur.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				R_STATUS: next_cur.rdata = {11'h000, cur.status};
				R_MASK: next_cur.rdata = {11'h000, cur.mask};
				R_ACTIVE: next_cur.rdata = {2'h0, cur.stop, cur.par, cur.baud, cur.addr};
				R_STORED: next_cur.rdata = cur.stored_comm;
				R_POWER: next_cur.rdata = {6'h00, cur.power};
				R_THRESH: next_cur.rdata = {6'h00, cur.thresh};
				R_INTEG: next_cur.rdata = {3'h0, cur.integ};
				R_FLASH: next_cur.rdata = {13'h0000, config_ready, cur.fstat};
				default: next_cur.rdata = 16'h0000;
			endcase
		end
		if (reg_wr && reg_addr == R_STATUS)
			next_cur.status = cur.status & ~reg_wdata[EV_BITS-1:0];
		if (reg_wr && reg_addr == R_MASK)
			next_cur.mask = reg_wdata[EV_BITS-1:0];
		if (reg_wr && reg_addr == R_CMD && reg_wdata[CMD_REBOOT_BIT] && cur.st == ST_RUN)
			reboot = 1'b1; // RULE11
		next_cur.status = next_cur.status | ev;
		if (reboot) begin
			next_cur.st = ST_RESET;
			next_cur.ready = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '{st: ST_RESET, addr: FALLBACK_ADDR, baud: BAUD_115200, // RULE1
				par: PARITY_NONE, stop: STOP_ONE, integ: INTEG_DEFAULT,
				fstat: FS_OK, acc: CHECK_SEED, default: '0};
		end else begin
			cur <= next_cur;
		end
	end

	assign reply_valid = cur.r_valid;
	assign reply_addr = cur.r_addr;
	assign reply_func = cur.r_func;
	assign reply_data = cur.r_data;
	assign node_addr = cur.addr;
	assign baud_code = cur.baud;
	assign parity_mode = cur.par;
	assign stop_bits = cur.stop;
	assign laser_power = cur.power;
	assign threshold = cur.thresh;
	assign integ_time = cur.integ;
	assign flash_status = cur.fstat;
	// Low until the apply step has set status and settings
	assign config_ready = cur.ready && (cur.st == ST_RUN || cur.st == ST_SAVE);
	assign reg_rdata = cur.rdata;
	assign irq = |(cur.status & cur.mask);

	sequence s_write_comm;
		frame_valid && accept && frame_func == FN_WRITE_COMM && cur.st == ST_RUN;
	endsequence

	property p_active_holds;
		@(posedge clk_sys) disable iff (!reset_n)
		s_write_comm |=> $stable(node_addr) && $stable(baud_code);
	endproperty
	a_active_holds: assert property (p_active_holds) else $error("settings changed early"); // RULE10

	property p_save_done;
		@(posedge clk_sys) disable iff (!reset_n)
		s_write_comm |-> ##5 (mem_wr && mem_waddr == UW_CHECK)
			##1 (cur.st == ST_RUN && cur.status[EV_SAVED]);
	endproperty
	a_save_done: assert property (p_save_done) else $error("save not finished"); // RULE10

	property p_fallback;
		@(posedge clk_sys) disable iff (!reset_n)
		cur.st == ST_APPLY && cur.acc != 16'h0000 |=>
			node_addr == FALLBACK_ADDR && baud_code == BAUD_115200 && parity_mode == PARITY_NONE;
	endproperty
	a_fallback: assert property (p_fallback) else $error("fallback settings wrong"); // RULE5

	property p_bad_user;
		@(posedge clk_sys) disable iff (!reset_n)
		cur.st == ST_APPLY && prot_good && cur.acc != 16'h0000 |=> flash_status == FS_BAD_USER;
	endproperty
	a_bad_user: assert property (p_bad_user) else $error("bad user status missing"); // RULE6

	property p_good;
		@(posedge clk_sys) disable iff (!reset_n)
		cur.st == ST_APPLY && prot_good && cur.acc == 16'h0000 |=> flash_status == FS_OK;
	endproperty
	a_good: assert property (p_good) else $error("ok status missing"); // RULE4

	property p_bad_prot;
		@(posedge clk_sys) disable iff (!reset_n)
		cur.st == ST_APPLY && !prot_good |=> flash_status == FS_BAD_PROT;
	endproperty
	a_bad_prot: assert property (p_bad_prot) else $error("bad protected status missing"); // RULE7

	property p_query;
		@(posedge clk_sys) disable iff (!reset_n)
		frame_valid && cur.st == ST_RUN && frame_addr == BCAST_ADDR
			&& frame_func == FN_QUERY_ADDR |=> reply_valid && reply_data[7:0] == $past(node_addr);
	endproperty
	a_query: assert property (p_query) else $error("address query unanswered"); // RULE12

	property p_ignore;
		@(posedge clk_sys) disable iff (!reset_n)
		frame_valid && frame_addr != node_addr && frame_addr != BCAST_ADDR |=> !reply_valid;
	endproperty
	a_ignore: assert property (p_ignore) else $error("answered foreign frame"); // RULE19

	property p_integ_range;
		@(posedge clk_sys) disable iff (!reset_n)
		config_ready |-> integ_time >= INTEG_MIN && integ_time <= INTEG_MAX;
	endproperty
	a_integ_range: assert property (p_integ_range) else $error("integration out of range"); // RULE18

	property p_reboot;
		@(posedge clk_sys) disable iff (!reset_n)
		frame_valid && accept && frame_func == FN_REBOOT |=> !config_ready ##[1:12] config_ready;
	endproperty
	a_reboot: assert property (p_reboot) else $error("reboot did not reload"); // RULE11
endmodule
`default_nettype wire

// File: host_link_model.sv
// Host side of the link: sends one frame at a time and captures the reply
`default_nettype none
module host_link_model
	import board_cfg_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Frame out
	output logic frame_valid,
	output logic [7:0] frame_addr,
	output logic [3:0] frame_func,
	output logic [15:0] frame_data0,
	output logic [15:0] frame_data1,
	output logic [15:0] frame_data2,
	// Reply in
	input wire logic reply_valid,
	input wire logic [7:0] reply_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic got;
	logic [7:0] got_addr;
	initial begin
		frame_valid = 1'b0;
		frame_addr = 8'h5a;
		frame_func = 4'ha;
		frame_data0 = 16'h0000;
		frame_data1 = 16'h0000;
		frame_data2 = 16'h0000;
		got = 1'b0;
		got_addr = 8'h00;
	end
	// Callers query broadcast with one board only, and give each board its own address
	task automatic send(input logic [7:0] a, input logic [3:0] f, input logic [15:0] d0,
			input logic [15:0] d1, input logic [15:0] d2);
		@(posedge clk_sys);
		frame_valid <= 1'b1;
		frame_addr <= a;
		frame_func <= f;
		frame_data0 <= d0;
		frame_data1 <= d1;
		frame_data2 <= d2;
		@(posedge clk_sys);
		// Released fields flip so stale values never look valid
		frame_valid <= 1'b0;
		frame_addr <= ~a;
		frame_func <= ~f;
		frame_data0 <= ~d0;
		frame_data1 <= ~d1;
		frame_data2 <= ~d2;
		@(negedge clk_sys);
		got = reply_valid;
		got_addr = reply_addr;
	endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the board configuration loader
`default_nettype none
module tb_top
	import board_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset_n, prot_ready, prot_good, laser_fault;
	logic [11:0] input_voltage;
	logic [15:0] serial_number, firmware_version;
	logic frame_valid, reply_valid, stop_bits, config_ready, reg_wr, reg_rd, irq;
	logic [7:0] frame_addr, reply_addr, node_addr;
	logic [3:0] frame_func, reply_func, reg_addr;
	logic [15:0] frame_data0, frame_data1, frame_data2, reg_wdata, reg_rdata, rv;
	logic [63:0] reply_data;
	logic [63:0] full_reply;
	logic [2:0] baud_code;
	logic [1:0] parity_mode, flash_status;
	logic [9:0] laser_power, threshold;
	logic [12:0] integ_time;
	int err_count, tests_run;

	board_cfg_loader dut (.clk_sys(clk_sys), .reset_n(reset_n), .prot_ready(prot_ready),
		.prot_good(prot_good), .laser_fault(laser_fault), .input_voltage(input_voltage),
		.serial_number(serial_number), .firmware_version(firmware_version),
		.frame_valid(frame_valid), .frame_addr(frame_addr), .frame_func(frame_func),
		.frame_data0(frame_data0), .frame_data1(frame_data1), .frame_data2(frame_data2),
		.reply_valid(reply_valid), .reply_addr(reply_addr), .reply_func(reply_func),
		.reply_data(reply_data), .node_addr(node_addr), .baud_code(baud_code),
		.parity_mode(parity_mode), .stop_bits(stop_bits), .laser_power(laser_power),
		.threshold(threshold), .integ_time(integ_time), .flash_status(flash_status),
		.config_ready(config_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

	host_link_model host (.clk_sys(clk_sys), .frame_valid(frame_valid),
		.frame_addr(frame_addr), .frame_func(frame_func), .frame_data0(frame_data0),
		.frame_data1(frame_data1), .frame_data2(frame_data2), .reply_valid(reply_valid),
		.reply_addr(reply_addr));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask

	// Bounded wait on the boot handshake
	task automatic wait_ready(input logic lvl);
		for (int i = 0; i < 300 && config_ready !== lvl; i++)
			@(negedge clk_sys);
		chk(config_ready, lvl);
	endtask

	task automatic reboot_wait();
		wait_ready(1'b0);
		wait_ready(1'b1);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		end_of_test();
	end

	initial begin
		err_count = 0;
		tests_run = 0;
		reset_n = 1'b0;
		prot_ready = 1'b1;
		prot_good = 1'b1;
		laser_fault = 1'b0;
		input_voltage = 12'h5a3;
		serial_number = 16'h1234;
		firmware_version = 16'h0102;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		// Blank image: its sum cannot cancel, so the first boot must fail
		for (int i = 0; i < USER_WORDS; i++)
			dut.u_mem.mem[i] = 16'h0000;
		repeat (12) @(posedge clk_sys);
		chk(node_addr, FALLBACK_ADDR);
		reset_n <= 1'b1;
		wait_ready(1'b1);
		// Empty flash image boots on factory settings
		chk(flash_status, FS_BAD_USER);
		chk({stop_bits, parity_mode, baud_code, node_addr}, 14'h07ff);
		reg_read(R_ACTIVE, rv);
		chk(rv, 16'h07ff);
		reg_read(R_FLASH, rv);
		chk(rv, 16'h0005);
		reg_read(R_STATUS, rv);
		chk(rv, 16'h0003);
		reg_read(4'hf, rv);
		chk(rv, 16'h0000);
		chk(irq, 1'b0);
		reg_write(R_MASK, 16'h0002);
		@(negedge clk_sys);
		chk(irq, 1'b1);
		reg_write(R_STATUS, 16'h0002);
		@(negedge clk_sys);
		chk(irq, 1'b0);
		// New comm settings are stored but not yet active; power, threshold and integration are checked after the reboot
		host.send(FALLBACK_ADDR, FN_WRITE_COMM, 16'h3322, 16'h0000, 16'h0000);
		repeat (8) @(posedge clk_sys);
		host.send(FALLBACK_ADDR, FN_WRITE_SET, 16'h03ff, 16'h02a5, 16'd5000);
		repeat (8) @(posedge clk_sys);
		chk(node_addr, FALLBACK_ADDR);
		chk(baud_code, BAUD_115200);
		reg_read(R_STORED, rv);
		chk(rv, 16'h3322);
		reg_read(R_STATUS, rv);
		chk(rv[EV_SAVED], 1'b1);
		reg_write(R_CMD, 16'h0001);
		reboot_wait();
		chk(flash_status, FS_OK);
		chk({stop_bits, parity_mode, baud_code, node_addr}, 14'h3322);
		chk({laser_power, threshold, integ_time}, {10'h3ff, 10'h2a5, INTEG_MAX});
		reg_read(R_POWER, rv);
		chk(rv, 16'h03ff);
		reg_read(R_THRESH, rv);
		chk(rv, 16'h02a5);
		reg_read(R_INTEG, rv);
		chk(rv, 16'h1045);
		host.send(8'h33, FN_READ_CFG, 16'h0000, 16'h0000, 16'h0000);
		chk(host.got, 1'b0);
		reg_read(R_STATUS, rv);
		chk(rv[EV_IGNORED], 1'b1);
		laser_fault <= 1'b1;
		host.send(8'h22, FN_READ_CFG, 16'h0000, 16'h0000, 16'h0000);
		full_reply = {1'b1, FS_OK, 12'h5a3, 16'h1234, 16'h0102, 10'h3ff, 7'h54};
		chk({host.got, host.got_addr, reply_func}, {1'b1, 8'h22, FN_READ_CFG});
		chk(reply_data, full_reply);
		host.send(BCAST_ADDR, FN_QUERY_ADDR, 16'h0000, 16'h0000, 16'h0000);
		chk({host.got, host.got_addr}, {1'b1, 8'h22});
		// Calibration area fails on the next boot
		prot_good <= 1'b0;
		host.send(8'h22, FN_REBOOT, 16'h0000, 16'h0000, 16'h0000);
		reboot_wait();
		chk(flash_status, FS_BAD_PROT);
		reg_read(R_STATUS, rv);
		chk(rv[EV_BAD_PROT], 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
